// >>> src/ghbp_defs.svh
// Constants of the generic host bus port: address map, strap codes, timing counts.
// Assumes inclusion by bare name from the port package and modules.
`ifndef GHBP_DEFS_SVH
`define GHBP_DEFS_SVH
`define GHBP_MEM_LAST 17'h13FFF
`define GHBP_REG_FIRST 17'h1FFE0
`define GHBP_REG_LAST 17'h1FFFF
`define GHBP_BUS_TYPE_GENERIC 3'h7
`define GHBP_CFG_SAMPLE_CYCLES 4'h8
`define GHBP_IDLE_DATA 16'h0000
`endif

// >>> src/ghbp_pkg.sv
// Types of the generic host bus port.
// Assumes ghbp_defs.svh is on the include path.
`include "ghbp_defs.svh"
package ghbp_pkg;
  typedef enum logic [2:0] {
    GHBP_ST_IDLE,
    GHBP_ST_ARB,
    GHBP_ST_XFER,
    GHBP_ST_DONE
  } ghbp_state_t;
  typedef enum logic {
    GHBP_MODE_ONE,
    GHBP_MODE_TWO
  } ghbp_mode_t;
endpackage : ghbp_pkg

// >>> src/ghbp_sync3.sv
// Three-stage synchroniser with agreement filter for one asynchronous pin.
// Assumes a synchronous active-low reset on the sampling clock.
`timescale 1ns/100ps
`default_nettype none
module ghbp_sync3 #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic pin_in,
  output logic level_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } ghbp_sync_t;
  ghbp_sync_t st_q;
  ghbp_sync_t st_d;

  // Only s2 and s3 feed the filter; s1 is read by s2 alone
  always_comb begin
    st_d = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.level = st_q.s3;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      st_q <= '{s1: RESET_VAL, s2: RESET_VAL, s3: RESET_VAL, level: RESET_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign level_out = st_q.level;
endmodule : ghbp_sync3
`default_nettype wire

// >>> src/ghbp_port.sv
// Generic host bus port: host slave in generic modes one and two, with wait and arbitration.
// Assumes a refresh requester and a memory/register back end on mclk_in, which is separate from
// the host bus clock; host strobes arrive asynchronously and are synchronised here.
// Operation
// - Sixteen-bit data, seventeen-bit address to host
// - Mode one: chip select, per-byte strobes
// - Mode one ignores bus status, tied low
// - Mode two: high byte enable both directions
// - Mode two: low write strobe is write
// - Mode two: read strobe drives read data
// - Mode two: status, read-write pins tied high
// - Active-low wait until data ready/accepted
// - Arbitrate host against display refresh
// - Port runs on mclk_in, not on the bus clock
// - Strobes accepted asynchronously to bus clock
// - Latch configuration pins after reset
// - Display memory at 0 through 13FFFh
// - Registers at 1FFE0h through 1FFFFh
`timescale 1ns/100ps
`default_nettype none
`include "ghbp_defs.svh"
module ghbp_port #(
  parameter int ADDR_W = 17,
  parameter int DATA_W = 16
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic [ADDR_W-1:0] host_addr_in,
  input wire logic [DATA_W-1:0] host_data_bus_in,
  output logic [DATA_W-1:0] host_data_bus_out,
  output logic host_data_bus_oe_b_out,
  input wire logic chip_select_n_in,
  input wire logic low_byte_write_strobe_n_in,
  input wire logic high_byte_write_strobe_n_in,
  input wire logic read_strobe_n_in,
  input wire logic read_write_pin_in,
  input wire logic bus_status_mode_pin_in,
  input wire logic [3:0] power_up_config_pins_in,
  output logic wait_n_out,
  output ghbp_pkg::ghbp_mode_t bus_mode_out,
  output logic big_endian_out,
  output logic [2:0] bus_type_select_out,
  output logic bad_bus_type_out,
  input wire logic refresh_req_in,
  output logic refresh_gnt_out,
  output logic mem_sel_out,
  output logic reg_sel_out,
  output logic back_req_out,
  output logic back_write_out,
  output logic [1:0] back_byte_en_out,
  output logic [ADDR_W-1:0] back_addr_out,
  output logic [DATA_W-1:0] back_wdata_out,
  input wire logic back_ack_in,
  input wire logic [DATA_W-1:0] back_rdata_in
);
  import ghbp_pkg::*;

  typedef struct packed {
    ghbp_state_t state;
    ghbp_mode_t mode;
    logic endian;
    logic [2:0] bus_type;
    logic [3:0] cfg_cnt;
    logic cfg_done;
    logic write;
    logic [1:0] byte_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic mem_sel;
    logic reg_sel;
    logic drive;
    logic req;
    logic gnt;
  } ghbp_port_t;

  ghbp_port_t st_q;
  ghbp_port_t st_d;

  logic cs_s, we0_s, we1_s, rd0_s, rd1_s, bs_s, end_s;
  logic [2:0] bt_s;
  logic [8:0] pins;
  logic [8:0] pins_s;

  // Every strobe and strap passes the three-stage filter
  assign pins = {power_up_config_pins_in, bus_status_mode_pin_in, read_write_pin_in,
                 read_strobe_n_in, high_byte_write_strobe_n_in, low_byte_write_strobe_n_in};

  ghbp_sync3 #(.RESET_VAL(1'b1)) u_sync_cs (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .pin_in(chip_select_n_in),
    .level_out(cs_s)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 9; gi++) begin : g_sync
      ghbp_sync3 #(.RESET_VAL(pins_rst_c(gi))) u_sync (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .pin_in(pins[gi]),
        .level_out(pins_s[gi])
      );
    end
  endgenerate

  function automatic logic pins_rst_c(input int i);
    pins_rst_c = (i < 5);
  endfunction : pins_rst_c

  assign {end_s, bt_s, bs_s, rd1_s, rd0_s, we1_s, we0_s} = pins_s;

  logic sel, any_rd, any_wr, lo_en, hi_en, in_mem, in_reg;

  always_comb begin
    // Mode one: per-byte strobes; read-write pin is the high-byte read
    // Mode two: high byte enable qualifies both directions
    if (st_q.mode == GHBP_MODE_ONE) begin
      any_wr = !we0_s || !we1_s;
      any_rd = !rd0_s || !rd1_s;
      lo_en = any_wr ? !we0_s : !rd0_s;
      hi_en = any_wr ? !we1_s : !rd1_s;
    end else begin
      any_wr = !we0_s;
      any_rd = !rd0_s;
      lo_en = 1'b1;
      hi_en = !we1_s;
    end
    sel = !cs_s && (any_wr || any_rd) && st_q.cfg_done;
    in_mem = st_q.addr <= `GHBP_MEM_LAST;
    in_reg = st_q.addr >= `GHBP_REG_FIRST;
  end

  always_comb begin
    st_d = st_q;
    // Straps are captured once the filtered pins settle after reset
    if (!st_q.cfg_done) begin
      st_d.cfg_cnt = st_q.cfg_cnt + 4'h1;
      if (st_q.cfg_cnt == `GHBP_CFG_SAMPLE_CYCLES) begin
        st_d.cfg_done = 1'b1;
        st_d.mode = bs_s ? GHBP_MODE_TWO : GHBP_MODE_ONE;
        st_d.endian = end_s;
        st_d.bus_type = bt_s;
      end
    end
    // Refresh wins while the host is idle; once a host access holds the grant it keeps it
    st_d.gnt = 1'b0;
    case (st_q.state)
      GHBP_ST_IDLE: begin
        st_d.drive = 1'b0;
        if (sel) begin
          st_d.state = GHBP_ST_ARB;
          st_d.write = any_wr;
          st_d.byte_en = {hi_en, lo_en};
          st_d.addr = host_addr_in;
          st_d.wdata = host_data_bus_in;
        end
      end
      GHBP_ST_ARB: begin
        if (!refresh_req_in) begin
          st_d.state = GHBP_ST_XFER;
          // Holes never raise a back-end request, so no ack is owed for them
          st_d.req = in_mem || in_reg;
          st_d.mem_sel = in_mem;
          st_d.reg_sel = in_reg;
        end
      end
      GHBP_ST_XFER: begin
        // Unmapped holes complete at once so wait is never held forever
        if (back_ack_in || !(st_q.mem_sel || st_q.reg_sel)) begin
          st_d.req = 1'b0;
          st_d.state = GHBP_ST_DONE;
          st_d.rdata = (st_q.mem_sel || st_q.reg_sel) ? back_rdata_in : `GHBP_IDLE_DATA;
          st_d.drive = !st_q.write;
        end
      end
      GHBP_ST_DONE: begin
        // Hold data until the host drops its strobe or chip select
        if (cs_s || !(any_rd || any_wr)) begin
          st_d.state = GHBP_ST_IDLE;
          st_d.drive = 1'b0;
        end
      end
      default: begin
        st_d.state = GHBP_ST_IDLE;
      end
    endcase
    if (st_d.state == GHBP_ST_IDLE) begin
      st_d.gnt = refresh_req_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Wait goes low as soon as a synchronised select is seen; the host's own sampling
  // must tolerate the filter latency before wait can appear
  assign wait_n_out = !(sel && st_q.state != GHBP_ST_DONE);
  assign host_data_bus_out = st_q.rdata;
  assign host_data_bus_oe_b_out = !(st_q.drive && !cs_s);
  assign bus_mode_out = st_q.mode;
  assign big_endian_out = st_q.endian;
  assign bus_type_select_out = st_q.bus_type;
  assign bad_bus_type_out = st_q.cfg_done && (st_q.bus_type != `GHBP_BUS_TYPE_GENERIC);
  assign refresh_gnt_out = st_q.gnt;
  assign mem_sel_out = st_q.mem_sel;
  assign reg_sel_out = st_q.reg_sel;
  assign back_req_out = st_q.req;
  assign back_write_out = st_q.write;
  assign back_byte_en_out = st_q.byte_en;
  assign back_addr_out = st_q.addr;
  assign back_wdata_out = st_q.wdata;
endmodule : ghbp_port
`default_nettype wire

// >>> verif/ghbp_port_checker.sv
// Pin-level assertions for the generic host bus port.
// Assumes it is bound to ghbp_port and shares its clock and reset.
`timescale 1ns/100ps
`default_nettype none
module ghbp_port_checker (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic chip_select_n_in,
  input wire logic read_strobe_n_in,
  input wire logic wait_n_out,
  input wire logic host_data_bus_oe_b_out,
  input wire ghbp_pkg::ghbp_mode_t bus_mode_out,
  input wire logic refresh_gnt_out,
  input wire logic mem_sel_out,
  input wire logic reg_sel_out,
  input wire logic back_req_out,
  input wire logic [1:0] back_byte_en_out,
  input wire logic back_ack_in
);
  import ghbp_pkg::*;
  default clocking dc @(posedge mclk_in);
  endclocking
  default disable iff (!rst_b_in);
  AST_OE_WAIT: assert property (!host_data_bus_oe_b_out |-> wait_n_out)
    else $error("bus driven while wait held");
  AST_REQ_HOLD: assert property (back_req_out && !back_ack_in |=> back_req_out)
    else $error("request dropped before ack");
  AST_ACK_DONE: assert property (back_req_out && back_ack_in |=> !back_req_out && wait_n_out)
    else $error("wait not released after ack");
  AST_REQ_WAIT: assert property (back_req_out |-> !wait_n_out)
    else $error("back request without wait");
  AST_GNT_EXCL: assert property (refresh_gnt_out |-> !back_req_out)
    else $error("refresh granted during host access");
  AST_SEL_EXCL: assert property (!(mem_sel_out && reg_sel_out))
    else $error("memory and register both selected");
  AST_LOW_BYTE: assert property (back_req_out && bus_mode_out == GHBP_MODE_TWO |-> back_byte_en_out[0])
    else $error("low byte off in mode two");
  AST_MODE_HOLD: assert property (!wait_n_out |=> $stable(bus_mode_out))
    else $error("mode changed during access");
  AST_WAIT_SYNC: assert property ($fell(wait_n_out) |-> !$past(chip_select_n_in, 2))
    else $error("wait before select was synchronised");
  AST_READ_OE: assert property ($rose(wait_n_out) && !read_strobe_n_in |-> !host_data_bus_oe_b_out)
    else $error("read done without driving bus");
endmodule : ghbp_port_checker
bind ghbp_port ghbp_port_checker ghbp_port_checker_i (.mclk_in, .rst_b_in, .chip_select_n_in,
  .read_strobe_n_in, .wait_n_out, .host_data_bus_oe_b_out, .bus_mode_out, .refresh_gnt_out,
  .mem_sel_out, .reg_sel_out, .back_req_out, .back_byte_en_out, .back_ack_in);
`default_nettype wire

// >>> verif/ghbp_host_model.sv
// Host processor with its glue logic, stepping on its own bus clock.
// Assumes the bench supplies that clock, the mode strap and the resolved data bus.
`timescale 1ns/100ps
`default_nettype none
module ghbp_host_model (
  input wire logic hclk_in,
  input wire logic mode_two_in,
  input wire logic wait_n_in,
  input wire logic [15:0] data_in,
  output logic [16:0] addr_out,
  output logic [15:0] data_out,
  output logic cs_n_out,
  output logic we0_n_out,
  output logic we1_n_out,
  output logic rd_n_out,
  output logic rdwr_n_out
);
  initial begin
    {cs_n_out, we0_n_out, we1_n_out, rd_n_out, rdwr_n_out} = 5'h1F;
    addr_out = 17'h00000;
    data_out = 16'hFFFF;
  end
  task automatic acc(input logic wr, input logic [1:0] be, input logic [16:0] a,
                     input logic [15:0] wd, output logic [15:0] rd);
    int n;
    @(posedge hclk_in) #1;
    addr_out = a;
    if (wr) data_out = wd;
    cs_n_out = 1'b0;
    we0_n_out = !(wr && (mode_two_in || be[0]));
    we1_n_out = !(be[1] && (wr || mode_two_in));
    rd_n_out = !(!wr && (mode_two_in || be[0]));
    rdwr_n_out = mode_two_in || wr || !be[1];
    n = 0;
    do begin
      @(posedge hclk_in);
      n++;
    end while (!wait_n_in && n < 50);
    rd = data_in;
    #1;
    {cs_n_out, we0_n_out, we1_n_out, rd_n_out, rdwr_n_out} = 5'h1F;
    // Released bus must not keep its last value
    data_out = ~data_out;
  endtask : acc
endmodule : ghbp_host_model
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench: host model, toy back end with adjustable ack delay.
// Assumes design, checker and host model are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import ghbp_pkg::*;
  logic clk = 0, hclk = 0, rstb = 0, bs = 0, rfq = 0, ack = 0, hit;
  logic cs, w0, w1, rn, rw, wt, oeb, gnt, req, bwe, cwe, ms, rs, big, badt;
  logic [1:0] bbe, cbe, cms;
  logic [2:0] typ;
  logic [3:0] cfg = 4'h7;
  logic [16:0] ha, bad, cad;
  logic [15:0] hd, dq, bwd, cwd, rd;
  ghbp_mode_t md;
  int fail_count = 0, n_tests = 0, nb = 0, cnt = 0, slow = 0;
  initial forever #2 clk = ~clk;
  initial begin
    #7;
    forever #32 hclk = ~hclk;
  end
  // Host data spans both byte lanes
  ghbp_port ghbp_port_i (.mclk_in(clk), .rst_b_in(rstb), .host_addr_in(ha),
    .host_data_bus_in(hd), .host_data_bus_out(dq), .host_data_bus_oe_b_out(oeb),
    .chip_select_n_in(cs), .low_byte_write_strobe_n_in(w0),
    .high_byte_write_strobe_n_in(w1), .read_strobe_n_in(rn), .read_write_pin_in(rw),
    .bus_status_mode_pin_in(bs), .power_up_config_pins_in(cfg), .wait_n_out(wt),
    .bus_mode_out(md), .big_endian_out(big), .bus_type_select_out(typ),
    .bad_bus_type_out(badt), .refresh_req_in(rfq), .refresh_gnt_out(gnt),
    .mem_sel_out(ms), .reg_sel_out(rs), .back_req_out(req), .back_write_out(bwe),
    .back_byte_en_out(bbe), .back_addr_out(bad), .back_wdata_out(bwd),
    .back_ack_in(ack), .back_rdata_in(ack ? cad[15:0] ^ 16'h5A3C : 16'h0000));
  ghbp_host_model ghbp_host_model_i (.hclk_in(hclk), .mode_two_in(bs), .wait_n_in(wt),
    .data_in(oeb ? hd : dq), .addr_out(ha), .data_out(hd), .cs_n_out(cs),
    .we0_n_out(w0), .we1_n_out(w1), .rd_n_out(rn), .rdwr_n_out(rw));
  always @(posedge clk) begin
    hit = req && !ack && cnt >= slow;
    ack <= #1 hit;
    cnt <= #1 (req && !ack) ? cnt + 1 : 0;
    if (hit) begin
      nb++;
      {cwe, cbe, cad, cwd, cms} = {bwe, bbe, bad, bwd, ms, rs};
    end
  end
  task automatic chk(string s, logic [16:0] g, logic [16:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic rst(logic m, logic [3:0] c);
    @(posedge clk) #1;
    rstb = 0;
    bs = m;
    cfg = c;
    repeat (6) @(posedge clk);
    #1 rstb = 1;
    repeat (30) @(posedge clk);
    #1;
    chk("mode", md, m);
    chk("endian", big, c[3]);
    chk("type", {badt, typ}, {c[2:0] != 3'h7, c[2:0]});
  endtask : rst
  task automatic xfer(logic wr, logic [1:0] be, logic [16:0] a, logic [15:0] d,
                      logic [1:0] es, logic [1:0] ebe);
    int n0;
    n0 = nb;
    ghbp_host_model_i.acc(wr, be, a, d, rd);
    chk("wait", wt, 1'b1);
    chk("backreq", 17'(nb - n0), es != 2'h0);
    if (es != 2'h0) begin
      chk("sel", cms, es);
      chk("dir", cwe, wr);
      chk("be", cbe, ebe);
      chk("addr", cad, a);
      if (wr) chk("wdata", cwd, d);
    end
    if (!wr && be == 2'h3) chk("rdata", rd, es != 2'h0 ? a[15:0] ^ 16'h5A3C : 16'h0000);
  endtask : xfer
  task automatic t_one;
    rst(0, 4'h7);
    xfer(1, 2'h3, 17'h00010, 16'hBEEF, 2'h2, 2'h3);
    xfer(1, 2'h1, 17'h13FFF, 16'h1234, 2'h2, 2'h1);
    xfer(1, 2'h2, 17'h1FFE0, 16'h5678, 2'h1, 2'h2);
    xfer(0, 2'h3, 17'h1FFFF, 16'h0000, 2'h1, 2'h3);
    xfer(0, 2'h3, 17'h14000, 16'h0000, 2'h0, 2'h0);
    xfer(0, 2'h2, 17'h00002, 16'h0000, 2'h2, 2'h2);
    $display("t_one done");
  endtask : t_one
  task automatic t_two;
    rst(1, 4'hF);
    xfer(1, 2'h2, 17'h00020, 16'hA5A5, 2'h2, 2'h3);
    xfer(1, 2'h1, 17'h1FFEE, 16'h0F0F, 2'h1, 2'h1);
    xfer(0, 2'h3, 17'h00020, 16'h0000, 2'h2, 2'h3);
    xfer(0, 2'h1, 17'h1FFE4, 16'h0000, 2'h1, 2'h1);
    $display("t_two done");
  endtask : t_two
  task automatic t_ref;
    // The last read leaves the port in its done state until the filter sees the release
    @(posedge clk) #1;
    slow = 4;
    rfq = 1;
    repeat (8) @(posedge clk);
    #1 chk("gnt", gnt, 1);
    fork
      xfer(0, 2'h3, 17'h00100, 16'h0000, 2'h2, 2'h3);
      begin
        repeat (60) @(posedge clk);
        #1 chk("stall", {wt, req}, 2'h0);
        rfq = 0;
      end
    join
    slow = 0;
    $display("t_ref done");
  endtask : t_ref
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  initial begin
    t_one;
    t_two;
    t_ref;
    rst(0, 4'h3);
    end_of_test;
  end
  initial begin
    #50us;
    fail_count++;
    end_of_test;
  end
endmodule : tb_top
`default_nettype wire
